// [hdl/alc_pkg.sv]
// Shared constants and types for the chain self-check and width compensation block
package alc_pkg;
    // ==========================================
    // Clock and timing
    localparam int CLK_NS = 10;
    localparam int PWM_PERIOD_NS = 250000;
    localparam int PWM_LEVELS = 256;
    localparam int PWM_SLOT_CYC = PWM_PERIOD_NS / (CLK_NS * PWM_LEVELS);
    localparam int COMP_STEP_NS = 260;
    localparam int COMP_STEP_CYC = (COMP_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC = SETTLE_US * 1000 / CLK_NS;
    localparam logic [2:0] COMP_MAX = 3'h6;
    // ==========================================
    // Register bus shape
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int NCH = 4;
    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COMP = 8'h04;
    localparam logic [7:0] OFF_START = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_DUTY0 = 8'h10;
    // ==========================================
    // Field positions
    localparam int CTRL_SELFCHK = 0;
    localparam int CTRL_AUTO_ADDR = 1;
    localparam int CTRL_AUTO_WRITE = 2;
    localparam int CTRL_ADAPTIVE = 3;
    localparam int CTRL_RERUN = 4;
    localparam int ST_DONE = 0;
    localparam int ST_FIRST = 1;
    localparam int ST_SHOW = 2;
    localparam int ST_SKIP = 3;
    localparam int START_W = 12;
    localparam int RED_CH = 0;
    // ==========================================
    // Reset values
    localparam logic [2:0] COMP_RST = 3'h0;
    localparam logic [11:0] START_RST = 12'h001;
    localparam logic [7:0] DUTY_RST = 8'h00;
    // ==========================================
    // Types
    typedef struct packed {
        logic selfchk_en;
        logic auto_addr;
        logic auto_write;
        logic adaptive;
    } alc_cfg_s;
    typedef enum logic [1:0] {
        SC_SETTLE,
        SC_SAMPLE,
        SC_SHOW,
        SC_IDLE
    } alc_sc_e;
endpackage

// [hdl/alc_width_ext.sv]
// One output channel on-time lengthening stage
`timescale 1ns/10ps
module alc_width_ext
    import alc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pulse_in,
    input wire logic [2:0] level,
    output logic pulse_out
);
    // ==========================================
    // State
    logic [7:0] hold_reg; // Remaining extension cycles
    logic [7:0] hold_next;
    logic out_reg; // Registered channel output
    logic out_next;

    assign pulse_out = out_reg;

    // Next state: restart hold on every on cycle, drain it when off
    always_comb
    begin
        hold_next = hold_reg;
        out_next = 1'b0;
        if (pulse_in)
        begin
            // Load level times step; a new pulse during the tail reloads the full hold
            hold_next = 8'(level * COMP_STEP_CYC);
            out_next = 1'b1;
        end
        else if (hold_reg != 8'h00)
        begin
            // Tail after the raw pulse falls; level zero never loads one
            hold_next = hold_reg - 8'h01;
            out_next = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_reg <= 8'h00;
            out_reg <= 1'b0;
        end
        else
        begin
            hold_reg <= hold_next;
            out_reg <= out_next;
        end
    end
endmodule

// [hdl/alc_top.sv]
// Chain self-check, PWM outputs and on-width compensation with register port
`timescale 1ns/10ps

module alc_top
    import alc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DW-1:0] rdata,
    input wire logic address_chain_input,
    output logic address_chain_output,
    output logic [NCH-1:0] out_pwm
);
    // ==========================================
    // Decode helper
    // Address match, used by the write and read paths
    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
        hit = (a == off);
    endfunction

    // ==========================================
    // Chain input synchroniser
    logic chain_s1_reg; // First stage, read only by the second
    logic chain_s2_reg; // Safe level
    logic chain_out_reg; // Level offered to the next lamp

    // Two flops in from the pin, steady high out to the next lamp
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chain_s1_reg <= 1'b0;
            chain_s2_reg <= 1'b0;
            chain_out_reg <= 1'b0;
        end
        else
        begin
            chain_s1_reg <= address_chain_input;
            chain_s2_reg <= chain_s1_reg;
            chain_out_reg <= 1'b1;
        end
    end

    assign address_chain_output = chain_out_reg;

    // ==========================================
    // Settings registers
    alc_cfg_s cfg_reg; // Self-check and automatic function bits
    alc_cfg_s cfg_next;
    logic [2:0] comp_reg; // Compensation level 0..6
    logic [2:0] comp_next;
    logic [START_W-1:0] start_reg; // Start channel address
    logic [START_W-1:0] start_next;
    logic [7:0] duty_reg [NCH]; // Grey level per channel
    logic [7:0] duty_next [NCH];
    logic rerun; // Software replay of the power-up check
    logic duty_wr; // Any grey level write
    logic [DW-1:0] rdata_reg; // Read answer
    logic [DW-1:0] rdata_next;

    // Next values of the settings from the write strobe
    always_comb
    begin
        cfg_next = cfg_reg;
        comp_next = comp_reg;
        start_next = start_reg;
        duty_next = duty_reg;
        rerun = 1'b0;
        duty_wr = 1'b0;
        if (wr_stb)
        begin
            if (hit(addr, OFF_CTRL))
            begin
                // Control bits other than rerun kept until rewritten; rerun is a one-cycle strobe
                cfg_next.selfchk_en = wdata[CTRL_SELFCHK];
                cfg_next.auto_addr = wdata[CTRL_AUTO_ADDR];
                cfg_next.auto_write = wdata[CTRL_AUTO_WRITE];
                cfg_next.adaptive = wdata[CTRL_ADAPTIVE];
                rerun = wdata[CTRL_RERUN];
            end
            if (hit(addr, OFF_COMP))
            begin
                // Out-of-range levels clamp to the top level
                comp_next = (wdata[2:0] > COMP_MAX) ? COMP_MAX : wdata[2:0];
            end
            if (hit(addr, OFF_START))
            begin
                // Full 12-bit start address, reached over the bus port only
                start_next = wdata[START_W-1:0];
            end
            for (int i = 0; i < NCH; i++)
            begin
                if (hit(addr, AW'(OFF_DUTY0 + 8'(4 * i))))
                begin
                    duty_next[i] = wdata[7:0];
                    duty_wr = 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Self-check sequencer
    alc_sc_e sc_reg; // Check state
    alc_sc_e sc_next;
    logic [15:0] settle_reg; // Settle counter after power-up
    logic [15:0] settle_next;
    logic first_reg; // Open line or first chip seen
    logic first_next;
    logic done_reg; // Check finished at least once
    logic done_next;
    logic skip_reg; // Check was skipped
    logic skip_next;
    logic auto_any; // Some automatic function is on

    assign auto_any = cfg_reg.auto_addr | cfg_reg.auto_write | cfg_reg.adaptive;

    // Next state of the check: settle, sample, show, idle
    always_comb
    begin
        sc_next = sc_reg;
        settle_next = settle_reg;
        first_next = first_reg;
        done_next = done_reg;
        skip_next = skip_reg;
        unique case (sc_reg)
            SC_SETTLE:
            begin
                // Let the upstream lamp drive its output first
                if (settle_reg >= 16'(SETTLE_CYCLES - 1))
                begin
                    sc_next = SC_SAMPLE;
                end
                else
                begin
                    settle_next = settle_reg + 16'h0001;
                end
            end
            SC_SAMPLE:
            begin
                done_next = 1'b1;
                if (!cfg_reg.selfchk_en || auto_any)
                begin
                    // Disabled or automatic mode: no check at all
                    skip_next = 1'b1;
                    sc_next = SC_IDLE;
                end
                else
                begin
                    // Floating input rests low on its pull-down: first chip
                    first_next = !chain_s2_reg;
                    skip_next = 1'b0;
                    sc_next = SC_SHOW;
                end
            end
            SC_SHOW:
            begin
                // Result stays lit until grey data arrives
                if (duty_wr)
                begin
                    sc_next = SC_IDLE;
                end
            end
            SC_IDLE:
            begin
                sc_next = SC_IDLE;
            end
        endcase
        if (rerun)
        begin
            // Replay the power-up sequence
            sc_next = SC_SETTLE;
            settle_next = 16'h0000;
            first_next = 1'b0;
        end
    end

    // ==========================================
    // Register read
    // Answer one cycle after the read strobe, zero elsewhere
    always_comb
    begin
        rdata_next = '0;
        if (rd_stb)
        begin
            if (hit(addr, OFF_CTRL))
            begin
                rdata_next[CTRL_SELFCHK] = cfg_reg.selfchk_en;
                rdata_next[CTRL_AUTO_ADDR] = cfg_reg.auto_addr;
                rdata_next[CTRL_AUTO_WRITE] = cfg_reg.auto_write;
                rdata_next[CTRL_ADAPTIVE] = cfg_reg.adaptive;
            end
            if (hit(addr, OFF_COMP))
            begin
                rdata_next[2:0] = comp_reg;
            end
            if (hit(addr, OFF_START))
            begin
                rdata_next[START_W-1:0] = start_reg;
            end
            if (hit(addr, OFF_STATUS))
            begin
                rdata_next[ST_DONE] = done_reg;
                rdata_next[ST_FIRST] = first_reg;
                rdata_next[ST_SHOW] = (sc_reg == SC_SHOW);
                rdata_next[ST_SKIP] = skip_reg;
            end
            for (int i = 0; i < NCH; i++)
            begin
                if (hit(addr, AW'(OFF_DUTY0 + 8'(4 * i))))
                begin
                    rdata_next[7:0] = duty_reg[i];
                end
            end
        end
    end

    assign rdata = rdata_reg;

    // Registers of settings, check and read answer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_reg <= '0;
            comp_reg <= COMP_RST;
            start_reg <= START_RST;
            for (int i = 0; i < NCH; i++)
            begin
                duty_reg[i] <= DUTY_RST;
            end
            sc_reg <= SC_SETTLE;
            settle_reg <= 16'h0000;
            first_reg <= 1'b0;
            done_reg <= 1'b0;
            skip_reg <= 1'b0;
            rdata_reg <= '0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            comp_reg <= comp_next;
            start_reg <= start_next;
            duty_reg <= duty_next;
            sc_reg <= sc_next;
            settle_reg <= settle_next;
            first_reg <= first_next;
            done_reg <= done_next;
            skip_reg <= skip_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================
    // PWM time base
    logic [7:0] slot_reg; // Cycles within one grey step
    logic [7:0] slot_next;
    logic [7:0] phase_reg; // Position in the PWM period
    logic [7:0] phase_next;

    // Step the phase once per slot
    always_comb
    begin
        slot_next = slot_reg + 8'h01;
        phase_next = phase_reg;
        if (slot_reg >= 8'(PWM_SLOT_CYC - 1))
        begin
            slot_next = 8'h00;
            phase_next = phase_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slot_reg <= 8'h00;
            phase_reg <= 8'h00;
        end
        else
        begin
            slot_reg <= slot_next;
            phase_reg <= phase_next;
        end
    end

    // ==========================================
    // Channel outputs
    generate
        for (genvar g = 0; g < NCH; g++)
        begin : g_ch
            logic raw; // Uncompensated on request
            // While showing the result only red may light
            assign raw = (sc_reg == SC_SHOW) ? ((g == RED_CH) && first_reg)
                                             : (phase_reg < duty_reg[g]);
            alc_width_ext u_ext
            (
                .clk(clk),
                .reset_n(reset_n),
                .pulse_in(raw),
                .level(comp_reg),
                .pulse_out(out_pwm[g])
            );
        end
    endgenerate
endmodule

// [bench/alc_upstream_model.sv]
// Upstream lamp as seen at the chain input pin
`timescale 1ns/10ps
module alc_upstream_model
(
    input wire logic link_ok,
    output logic chain_level
);
    // ==========================================
    // Live link drives high, open pin pulled low
    assign chain_level = link_ok ? 1'b1 : 1'b0;
endmodule

// [bench/alc_top_monitor.sv]
// Port checker for the chain self-check and width block
`timescale 1ns/10ps
module alc_top_monitor
    import alc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [DW-1:0] rdata,
    input wire logic address_chain_input,
    input wire logic address_chain_output,
    input wire logic [NCH-1:0] out_pwm
);
    // ==========================================
    // Set once any duty slot is written
    logic seen_reg;
    logic seen_next;
    always_comb
    begin
        seen_next = seen_reg | (wr_stb & (addr[7:4] == 4'h1));
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            seen_reg <= 1'b0;
        end
        else
        begin
            seen_reg <= seen_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // Assertions
    AST_RD_IDLE: assert property (!$past(rd_stb) |-> rdata == '0)
        else $error("rdata not zero outside read slot");
    AST_CTRL_RD: assert property (rd_stb && addr == OFF_CTRL |=> rdata[31:4] == '0)
        else $error("control readback has stray bits");
    AST_COMP_WR: assert property (wr_stb && addr == OFF_COMP ##2 rd_stb && addr == OFF_COMP
        |=> rdata[2:0] == (($past(wdata[2:0], 3) > COMP_MAX) ? COMP_MAX : $past(wdata[2:0], 3)))
        else $error("compensation level not held or clipped");
    AST_START_RD: assert property (rd_stb && addr == OFF_START |=> rdata[31:12] == '0)
        else $error("start address wider than twelve bits");
    AST_STAT_RD: assert property (rd_stb && addr == OFF_STATUS
        |=> rdata[31:4] == '0 && !(rdata[ST_SKIP] && rdata[ST_SHOW]))
        else $error("skipped check still showing");
    AST_UNMAP: assert property (rd_stb && addr == 8'h20 |=> rdata == '0)
        else $error("unmapped read not zero");
    AST_CHAIN: assert property ($past(reset_n) |-> address_chain_output)
        else $error("chain output low after reset");
    AST_DARK: assert property (!seen_reg |-> out_pwm[3:1] == '0)
        else $error("non-red output lit during check");
    AST_RED: assert property ($rose(out_pwm[RED_CH]) && !seen_reg |-> !address_chain_input)
        else $error("red lit with chain connected");
    // ==========================================
    // Coverage
    CV_RED: cover property ($rose(out_pwm[RED_CH]));
    CV_STAT: cover property (rd_stb && addr == OFF_STATUS);
    CV_COMP: cover property (wr_stb && addr == OFF_COMP);
endmodule
bind alc_top alc_top_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) alc_top_monitor_inst
(
    .clk(clk),
    .reset_n(reset_n),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .address_chain_input(address_chain_input),
    .address_chain_output(address_chain_output),
    .out_pwm(out_pwm)
);

// [bench/tb_top.sv]
// Self-checking bench for the chain self-check and width block
`timescale 1ns/10ps
module tb_top
    import alc_pkg::*;
;
    localparam int SC = 20;
    logic clk;
    logic reset_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [DW-1:0] rdata;
    logic link_ok;
    logic chain_in;
    logic chain_out;
    logic [NCH-1:0] out_pwm;
    int fails;
    int num_checks;
    int hi [NCH];
    logic [DW-1:0] skips [4] = '{32'h13, 32'h15, 32'h19, 32'h10};
    int lvls [2] = '{0, 6};
    alc_top #(.SETTLE_CYCLES(SC)) alc_top_inst
    (
        .clk(clk),
        .reset_n(reset_n),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata),
        .address_chain_input(chain_in),
        .address_chain_output(chain_out),
        .out_pwm(out_pwm)
    );
    alc_upstream_model alc_upstream_model_inst
    (
        .link_ok(link_ok),
        .chain_level(chain_in)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================
    // Tasks
    task automatic tally_and_finish();
        if (fails == 0 && num_checks > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        // Take the answer mid-cycle, away from the edges that launch and clear it
        @(negedge clk);
        chk(rdata & m, e);
        @(posedge clk);
    endtask
    // Bounded wait for a fresh rise of one channel
    task automatic wait_rise(input int ch);
        int n;
        logic prev;
        n = 0;
        prev = 1'b1;
        while (!(prev === 1'b0 && out_pwm[ch] === 1'b1))
        begin
            prev = out_pwm[ch];
            @(posedge clk);
            n++;
            if (n > 30000)
            begin
                fails++;
                tally_and_finish();
            end
        end
    endtask
    task automatic measure(input int len);
        hi = '{default: 0};
        repeat (len)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                hi[c] += int'(out_pwm[c] === 1'b1);
            end
            @(posedge clk);
        end
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        fails = 0;
        num_checks = 0;
        reset_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        link_ok = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_chk(OFF_CTRL, '1, '0);
        rd_chk(OFF_COMP, '1, '0);
        rd_chk(OFF_START, '1, 32'h1);
        // Chain output offered to the next lamp once out of reset
        chk(DW'(chain_out), 32'h1);
        wr(8'h20, 32'hFFFFFFFF);
        rd_chk(8'h20, '1, '0);
        wr(OFF_CTRL, 32'h1);
        repeat (SC + 8) @(posedge clk);
        rd_chk(OFF_STATUS, 32'hF, 32'h7);
        chk(DW'(out_pwm), 32'h1);
        link_ok <= 1'b1;
        wr(OFF_CTRL, 32'h11);
        repeat (SC + 8) @(posedge clk);
        rd_chk(OFF_STATUS, 32'hF, 32'h5);
        chk(DW'(out_pwm), '0);
        rd_chk(OFF_CTRL, '1, 32'h1);
        link_ok <= 1'b0;
        foreach (skips[i])
        begin
            wr(OFF_CTRL, skips[i]);
            repeat (SC + 8) @(posedge clk);
            rd_chk(OFF_STATUS, 32'hC, 32'h8);
            chk(DW'(out_pwm), '0);
        end
        wr(OFF_START, 32'h1FFF);
        rd_chk(OFF_START, '1, 32'hFFF);
        wr(OFF_COMP, 32'h7);
        rd_chk(OFF_COMP, '1, 32'h6);
        for (int c = 0; c < NCH; c++)
        begin
            wr(OFF_DUTY0 + AW'(4 * c), 32'h1);
        end
        foreach (lvls[i])
        begin
            wr(OFF_COMP, DW'(lvls[i]));
            rd_chk(OFF_COMP, '1, DW'(lvls[i]));
            wait_rise(1);
            measure(300);
            for (int c = 0; c < NCH; c++)
            begin
                chk(DW'(hi[c]), DW'(PWM_SLOT_CYC + COMP_STEP_CYC * lvls[i]));
            end
        end
        wr(OFF_DUTY0 + 8'h04, 32'hFF);
        repeat (10) @(posedge clk);
        measure(25000);
        chk(DW'(hi[1]), DW'(25000));
        tally_and_finish();
    end
endmodule
